// ===== design/mcu_decode_pkg.sv
// constants, types and helpers shared by the instruction decoder
package mcu_decode_pkg;
    // widths of the instruction word and its operand fields
    localparam int WORD_W = 14;
    localparam int FADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int LIT_W = 11;
    localparam int BSEL_W = 3;
    // field positions within the instruction word
    localparam int CLS_MSB = 13;
    localparam int CLS_LSB = 12;
    localparam int OP_MSB = 11;
    localparam int OP_LSB = 8;
    localparam int DEST_POS = 7;
    localparam int BSEL_MSB = 9;
    localparam int BSEL_LSB = 7;
    localparam int OPSEL_POS = 11;
    localparam int TEST_POS = 10;
    // class codes in the two top bits
    localparam logic [1:0] CLS_BYTE = 2'h0;
    localparam logic [1:0] CLS_BIT = 2'h1;
    localparam logic [1:0] CLS_JUMP = 2'h2;
    localparam logic [1:0] CLS_LIT = 2'h3;
    // byte operation codes that need special handling
    localparam logic [3:0] OP_CTRL = 4'h0;
    localparam logic [3:0] OP_DECSKIP = 4'hB;
    localparam logic [3:0] OP_INCSKIP = 4'hF;
    // top two op bits of the literal-return operation
    localparam logic [1:0] LOP_RETLIT = 2'h1;
    // whole control words
    localparam logic [13:0] W_NOP = 14'h0000;
    localparam logic [13:0] W_RETURN = 14'h0008;
    localparam logic [13:0] W_RETINT = 14'h0009;
    // file address of the program counter low byte
    localparam logic [6:0] FADDR_PCL = 7'h02;
    // oscillator periods per instruction cycle
    localparam int PHASES = 4;
    localparam logic [7:0] DATA_RST = 8'h00;

    typedef enum logic [1:0] {GRP_BYTE, GRP_BIT, GRP_LIT} grp_e;
    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_e;

    // operand fields presented to the datapath
    typedef struct packed {
        grp_e grp;
        logic [3:0] op;
        logic [FADDR_W-1:0] faddr;
        logic dest;
        logic [BSEL_W-1:0] bsel;
        logic [DATA_W-1:0] lit8;
        logic [LIT_W-1:0] lit11;
    } fields_s;

    // split a word into fields; only class bits choose the group
    function automatic fields_s decode(input logic [WORD_W-1:0] w);
        fields_s f;
        f.grp = (w[CLS_MSB:CLS_LSB] == CLS_BYTE) ? GRP_BYTE :
                (w[CLS_MSB:CLS_LSB] == CLS_BIT) ? GRP_BIT : GRP_LIT;
        f.op = w[OP_MSB:OP_LSB];
        f.faddr = w[FADDR_W-1:0];
        f.dest = w[DEST_POS];
        f.bsel = w[BSEL_MSB:BSEL_LSB];
        f.lit8 = w[DATA_W-1:0];
        f.lit11 = w[LIT_W-1:0];
        return f;
    endfunction : decode

    // one-hot mask for a bit position
    function automatic logic [DATA_W-1:0] bit_mask(input logic [2:0] b);
        return 8'h01 << b;
    endfunction : bit_mask
endpackage : mcu_decode_pkg

// ===== design/mcu_instruction_decode.sv
// instruction decoder with four-phase cycle and read-modify-write control
`timescale 1ns/1ps
`default_nettype none
module mcu_instruction_decode (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RST_N,
    // program memory side
    input wire logic [13:0] I_PROG_WORD,
    output var logic O_FETCH,
    // register file and datapath side
    input wire logic [7:0] I_FILE_RDATA,
    input wire logic I_IO_SEL,
    input wire logic [7:0] I_PIN_DATA,
    input wire logic [7:0] I_ALU_RESULT,
    input wire logic I_ALU_ZERO,
    // decoded fields and timing
    output var logic [1:0] O_PHASE,
    output var mcu_decode_pkg::fields_s O_FIELDS,
    output var logic O_FILE_RD,
    output var logic [7:0] O_MOD_DATA,
    output var logic O_FILE_WR,
    output var logic O_WREG_WR,
    output var logic [7:0] O_WDATA,
    output var logic O_BRANCH,
    output var logic O_FLUSH
);
    mcu_decode_pkg::phase_e phase_q, phase_d;
    logic [13:0] ir_q, ir_d;
    mcu_decode_pkg::fields_s fields_q, fields_d;
    logic fetch_q, fetch_d;
    logic flush_q, flush_d;
    logic branch_q, branch_d;
    logic [7:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_q, pin_d;
    logic rd_q, rd_d;
    logic [7:0] mod_q, mod_d;
    logic wr_q, wr_d;
    logic wreg_q, wreg_d;
    logic [7:0] wdata_q, wdata_d;
    logic named, pc_write, jump, skip, is_byte, is_bit;

    // classify the executing word; only class bits and fixed bits matter
    // don't-care tolerant
    always_comb begin
        is_byte = fields_q.grp == mcu_decode_pkg::GRP_BYTE;
        is_bit = fields_q.grp == mcu_decode_pkg::GRP_BIT;
        named = is_bit || (is_byte &&
            (fields_q.dest || fields_q.op[3:1] != 3'h0));
        // any file store to the low program counter byte
        pc_write = ((is_byte && fields_q.dest) ||
                    (is_bit && !fields_q.op[3])) &&
            fields_q.faddr == mcu_decode_pkg::FADDR_PCL;
        jump = ir_q[13:12] == mcu_decode_pkg::CLS_JUMP ||
            ir_q == mcu_decode_pkg::W_RETURN ||
            ir_q == mcu_decode_pkg::W_RETINT ||
            (ir_q[13:12] == mcu_decode_pkg::CLS_LIT &&
             fields_q.op[3:2] == mcu_decode_pkg::LOP_RETLIT);
        // bit test skips when the tested bit equals the sense bit
        skip = (is_bit && fields_q.op[3] &&
                mod_q[fields_q.bsel] == fields_q.op[2]) ||
            (is_byte && I_ALU_ZERO &&
             (fields_q.op == mcu_decode_pkg::OP_DECSKIP ||
              fields_q.op == mcu_decode_pkg::OP_INCSKIP));
    end

    // phase sequencer, fetch and flush control
    always_comb begin
        phase_d = phase_q;
        ir_d = ir_q;
        fields_d = fields_q;
        fetch_d = 1'b0;
        flush_d = flush_q;
        branch_d = 1'b0;
        unique case (phase_q)
            mcu_decode_pkg::PH_Q1: phase_d = mcu_decode_pkg::PH_Q2;
            mcu_decode_pkg::PH_Q2: phase_d = mcu_decode_pkg::PH_Q3;
            mcu_decode_pkg::PH_Q3: phase_d = mcu_decode_pkg::PH_Q4;
            mcu_decode_pkg::PH_Q4: begin
                phase_d = mcu_decode_pkg::PH_Q1;
                fetch_d = 1'b1;
                branch_d = skip || jump || pc_write;
                flush_d = branch_d;
                // on a branch the prefetched word is dropped; a NOP runs instead
                // whole word held
                ir_d = branch_d ? mcu_decode_pkg::W_NOP : I_PROG_WORD;
                fields_d = mcu_decode_pkg::decode(ir_d);
            end
        endcase
    end

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            phase_q <= mcu_decode_pkg::PH_Q1;
            ir_q <= mcu_decode_pkg::W_NOP;
            fields_q <= '0;
            fetch_q <= 1'b0;
            flush_q <= 1'b0;
            branch_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            ir_q <= ir_d;
            fields_q <= fields_d;
            fetch_q <= fetch_d;
            flush_q <= flush_d;
            branch_q <= branch_d;
        end
    end

    // pin levels: three stages, accepted once stages two and three agree
    // a pin caught mid-change never reaches the modify step
    always_comb begin
        pin_d = pin_q;
        if (pin_s2_q == pin_s3_q) begin
            pin_d = pin_s3_q;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            pin_s1_q <= mcu_decode_pkg::DATA_RST;
            pin_s2_q <= mcu_decode_pkg::DATA_RST;
            pin_s3_q <= mcu_decode_pkg::DATA_RST;
            pin_q <= mcu_decode_pkg::DATA_RST;
        end else begin
            pin_s1_q <= I_PIN_DATA;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            pin_q <= pin_d;
        end
    end

    // read in q2, capture in q3, store in q4
    always_comb begin
        rd_d = 1'b0;
        mod_d = mod_q;
        wr_d = 1'b0;
        wreg_d = 1'b0;
        wdata_d = wdata_q;
        // clear of a port still reads it
        if (phase_q == mcu_decode_pkg::PH_Q1) begin
            rd_d = named;
        end
        if (rd_q) begin
            mod_d = I_IO_SEL ? pin_q : I_FILE_RDATA;
        end
        if (phase_q == mcu_decode_pkg::PH_Q3) begin
            wr_d = (is_byte && fields_q.dest) ||
                (is_bit && !fields_q.op[3]);
            wreg_d = (is_byte && !fields_q.dest &&
                      fields_q.op != mcu_decode_pkg::OP_CTRL) ||
                fields_q.grp == mcu_decode_pkg::GRP_LIT &&
                ir_q[13:12] == mcu_decode_pkg::CLS_LIT;
            wdata_d = I_ALU_RESULT;
            if (is_bit) begin
                wdata_d = fields_q.op[2] ?
                    mod_q | mcu_decode_pkg::bit_mask(fields_q.bsel) :
                    mod_q & ~mcu_decode_pkg::bit_mask(fields_q.bsel);
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rd_q <= 1'b0;
            mod_q <= mcu_decode_pkg::DATA_RST;
            wr_q <= 1'b0;
            wreg_q <= 1'b0;
            wdata_q <= mcu_decode_pkg::DATA_RST;
        end else begin
            rd_q <= rd_d;
            mod_q <= mod_d;
            wr_q <= wr_d;
            wreg_q <= wreg_d;
            wdata_q <= wdata_d;
        end
    end

    // outputs straight from flops
    assign O_PHASE = phase_q;
    assign O_FETCH = fetch_q;
    assign O_FIELDS = fields_q;
    assign O_FILE_RD = rd_q;
    assign O_MOD_DATA = mod_q;
    assign O_FILE_WR = wr_q;
    assign O_WREG_WR = wreg_q;
    assign O_WDATA = wdata_q;
    assign O_BRANCH = branch_q;
    assign O_FLUSH = flush_q;

    // checks of the decoder behaviour
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_N);

    property p_four_phase;
        O_FETCH |=> !O_FETCH [*3] ##1 O_FETCH;
    endproperty
    a_four_phase: assert property (p_four_phase)
        else $error("instruction cycle is not four clocks");

    property p_read_first;
        O_FILE_WR |-> $past(O_FILE_RD, 2);
    endproperty
    a_read_first: assert property (p_read_first)
        else $error("file store without earlier read");

    property p_clear_reads;
        O_FILE_WR && O_FIELDS.grp == mcu_decode_pkg::GRP_BYTE &&
            O_FIELDS.op == 4'h1 |-> $past(O_FILE_RD, 2);
    endproperty
    a_clear_reads: assert property (p_clear_reads)
        else $error("clear of a file skipped its read");

    property p_dest;
        O_FIELDS.grp == mcu_decode_pkg::GRP_BYTE && (O_FILE_WR || O_WREG_WR)
            |-> O_FIELDS.dest == O_FILE_WR;
    endproperty
    a_dest: assert property (p_dest)
        else $error("result went to the wrong destination");

    property p_bit_write;
        O_FILE_WR && O_FIELDS.grp == mcu_decode_pkg::GRP_BIT |->
            (O_WDATA ^ O_MOD_DATA) ==
            mcu_decode_pkg::bit_mask(O_FIELDS.bsel) * 8'(O_FIELDS.op[2] !=
            O_MOD_DATA[O_FIELDS.bsel]);
    endproperty
    a_bit_write: assert property (p_bit_write)
        else $error("bit operation touched the wrong bit");

    property p_flush;
        O_BRANCH |-> O_FLUSH [*4] ##1 !O_FLUSH;
    endproperty
    a_flush: assert property (p_flush)
        else $error("taken branch not followed by a NOP cycle");

    property p_flush_quiet;
        O_FLUSH |-> !O_FILE_RD && !O_FILE_WR && !O_WREG_WR;
    endproperty
    a_flush_quiet: assert property (p_flush_quiet)
        else $error("flushed cycle did work");

    property p_pins;
        O_FILE_RD && I_IO_SEL |=> O_MOD_DATA == $past(pin_q);
    endproperty
    a_pins: assert property (p_pins)
        else $error("io modify did not use pin levels");

    property p_fields_timely;
        O_FILE_RD |-> $past(O_FETCH) && O_PHASE == 2'(mcu_decode_pkg::PH_Q2);
    endproperty
    a_fields_timely: assert property (p_fields_timely)
        else $error("file read outside the executing cycle");

    property p_literal;
        O_FETCH && !O_FLUSH |-> O_FIELDS.lit8 == O_FIELDS.lit11[7:0] &&
            O_FIELDS.lit11 == $past(I_PROG_WORD[10:0]);
    endproperty
    a_literal: assert property (p_literal)
        else $error("literal fields disagree");

    // fields must hold for the whole cycle the datapath works on them
    property p_fields_stand;
        !O_FETCH |-> $stable(O_FIELDS);
    endproperty
    a_fields_stand: assert property (p_fields_stand)
        else $error("fields changed inside an instruction cycle");

    property p_store_q4;
        O_FILE_WR || O_WREG_WR |-> O_PHASE == 2'(mcu_decode_pkg::PH_Q4);
    endproperty
    a_store_q4: assert property (p_store_q4)
        else $error("store outside the last phase");

    c_branch: cover property (O_BRANCH);
    c_io_read: cover property (O_FILE_RD && I_IO_SEL);
    c_bit_write: cover property (O_FILE_WR &&
        O_FIELDS.grp == mcu_decode_pkg::GRP_BIT);
    c_w_write: cover property (O_WREG_WR);
    c_pc_write: cover property (O_BRANCH && $past(O_FILE_WR));
endmodule : mcu_instruction_decode
`default_nettype wire

// ===== verification/prog_mem_model.sv
// program memory model feeding one instruction word per cycle
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
    // cycle phase from the decoder
    input wire logic [1:0] i_phase,
    // word queued by the bench for the next fetch
    input wire logic [13:0] i_next_word,
    // word bus toward the decoder
    output logic [13:0] o_word
);
    // whole word
    // only guaranteed from Q2 on; Q1 shows the inverse so stale data shows
    assign o_word = (i_phase == 2'h0) ? ~i_next_word : i_next_word;
endmodule : prog_mem_model
`default_nettype wire

// ===== verification/mcu_instruction_decode_tb_top.sv
// self-checking bench for the instruction decoder
`timescale 1ns/1ps
`default_nettype none
module mcu_instruction_decode_tb_top;
    logic I_CLK = 1'b0;
    logic I_RST_N = 1'b0;
    logic [13:0] pend = 14'h0000;
    logic [13:0] I_PROG_WORD;
    logic [7:0] I_FILE_RDATA = 8'h00;
    logic I_IO_SEL = 1'b0;
    logic [7:0] I_PIN_DATA = 8'h00;
    logic [7:0] I_ALU_RESULT = 8'h00;
    logic I_ALU_ZERO = 1'b0;
    logic O_FETCH, O_FILE_RD, O_FILE_WR, O_WREG_WR, O_BRANCH, O_FLUSH;
    logic [1:0] O_PHASE;
    logic [7:0] O_MOD_DATA, O_WDATA;
    mcu_decode_pkg::fields_s O_FIELDS;
    int error_cnt = 0;
    int comparisons = 0;
    logic [15:0] seed = 16'hA2C1;
    // corner words; bit 14 carries the zero flag for the skip ops
    // no-op with don't-care bits set, queued behind each word under test
    logic [13:0] fill_word = 14'h0060;
    logic [14:0] corners [20] = '{15'h0000, 15'h0060, 15'h3000, 15'h3300,
        15'h0186, 15'h0100, 15'h0086, 15'h0782, 15'h4B20, 15'h0F20,
        15'h1820, 15'h1C20, 15'h15A0, 15'h11A0, 15'h2800, 15'h27FF,
        15'h0008, 15'h0009, 15'h3455, 15'h1402};

    // half period of the 40 MHz oscillator
    always #12.5 I_CLK = ~I_CLK;

    mcu_instruction_decode mcu_instruction_decode_inst (.I_CLK(I_CLK),
        .I_RST_N(I_RST_N), .I_PROG_WORD(I_PROG_WORD), .O_FETCH(O_FETCH),
        .I_FILE_RDATA(I_FILE_RDATA), .I_IO_SEL(I_IO_SEL),
        .I_PIN_DATA(I_PIN_DATA), .I_ALU_RESULT(I_ALU_RESULT),
        .I_ALU_ZERO(I_ALU_ZERO), .O_PHASE(O_PHASE), .O_FIELDS(O_FIELDS),
        .O_FILE_RD(O_FILE_RD), .O_MOD_DATA(O_MOD_DATA),
        .O_FILE_WR(O_FILE_WR), .O_WREG_WR(O_WREG_WR), .O_WDATA(O_WDATA),
        .O_BRANCH(O_BRANCH), .O_FLUSH(O_FLUSH));
    prog_mem_model prog_mem_model_inst (.i_phase(O_PHASE),
        .i_next_word(pend), .o_word(I_PROG_WORD));

    // sixteen-bit maximal-length shift register
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr

    // expected operand fields of a word, straight from the field layout
    function automatic mcu_decode_pkg::fields_s fields_of(
            input logic [13:0] w);
        mcu_decode_pkg::fields_s f;
        f.grp = (w[13:12] == 2'h0) ? mcu_decode_pkg::GRP_BYTE :
                (w[13:12] == 2'h1) ? mcu_decode_pkg::GRP_BIT :
                mcu_decode_pkg::GRP_LIT;
        f.op = w[11:8];
        f.faddr = w[6:0];
        f.dest = w[7];
        f.bsel = w[9:7];
        f.lit8 = w[7:0];
        f.lit11 = w[10:0];
        return f;
    endfunction : fields_of

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    // one instruction: queue at Q1, run its cycle, look at the next Q1
    task automatic exec(input logic [13:0] w, input logic z,
                        input logic [7:0] rd, input logic [7:0] alu,
                        input logic [7:0] pins, input logic io);
        logic [1:0] c;
        logic [3:0] op;
        logic d, fl, wr, fw, br, bv;
        logic [7:0] m, wd, msk;
        logic [13:0] nxt;
        c = w[13:12];
        op = w[11:8];
        d = w[7];
        fl = (c == 2'h1) || (c == 2'h0 && (d || op >= 4'h2));
        m = (io && fl) ? pins : rd;
        msk = 8'h01 << w[9:7];
        bv = m[w[9:7]];
        if (c == 2'h3 && op[3:2] == mcu_decode_pkg::LOP_RETLIT) alu = w[7:0];
        wr = (c == 2'h0 && !d && op != 4'h0) || c == 2'h3;
        fw = (c == 2'h0 && d) || (c == 2'h1 && !op[3]);
        wd = (c != 2'h1) ? alu : (op[2] ? (m | msk) : (m & ~msk));
        br = c == 2'h2 || w == mcu_decode_pkg::W_RETURN
            || w == mcu_decode_pkg::W_RETINT
            || (c == 2'h3 && op[3:2] == mcu_decode_pkg::LOP_RETLIT)
            || (fw && w[6:0] == mcu_decode_pkg::FADDR_PCL)
            || (c == 2'h1 && op[3] && (op[2] ? bv : !bv))
            || (c == 2'h0 && z && (op == mcu_decode_pkg::OP_DECSKIP
                || op == mcu_decode_pkg::OP_INCSKIP));
        // a taken branch must drop the live word queued behind this one
        nxt = br ? mcu_decode_pkg::W_NOP : fill_word;
        pend = w;
        I_PIN_DATA = pins;
        repeat (4) @(negedge I_CLK);
        chk(O_FETCH, 1'b1);
        chk(O_FIELDS, fields_of(w));
        pend = fill_word;
        I_FILE_RDATA = rd;
        I_IO_SEL = io & fl;
        I_ALU_RESULT = alu;
        I_ALU_ZERO = z;
        @(negedge I_CLK);
        chk(O_FILE_RD, fl);
        @(negedge I_CLK);
        if (fl) chk(O_MOD_DATA, m);
        @(negedge I_CLK);
        chk(O_FILE_WR, fw);
        chk(O_WREG_WR, wr);
        if (fw || wr) chk(O_WDATA, wd);
        @(negedge I_CLK);
        chk(O_BRANCH, br);
        chk(O_FLUSH, br);
        chk(O_FIELDS, fields_of(nxt));
        I_IO_SEL = 1'b0;
    endtask : exec

    // cut a hang short well past the expected run time
    initial begin
        #50000;
        error_cnt++;
        $display("Error at %0t: watchdog expired", $time);
        summarize();
    end

    initial begin
        logic [13:0] w;
        repeat (4) @(negedge I_CLK);
        chk(O_PHASE, 2'h0);
        chk({O_FETCH, O_FILE_WR, O_WREG_WR, O_BRANCH}, 4'h0);
        I_RST_N = 1'b1;
        // corner words: don't-care bits, port clear, skips, jumps
        foreach (corners[i]) begin
            seed = lfsr(seed);
            exec(corners[i][13:0], corners[i][14], seed[7:0], seed[15:8],
                 ~seed[7:0], 1'b1);
        end
        $display("test corner done");
        // random words with random file, pin and datapath data
        repeat (40) begin
            seed = lfsr(seed);
            w = seed[13:0];
            seed = lfsr(seed);
            exec(w, seed[15], seed[7:0], seed[14:7], ~seed[11:4],
                 seed[3]);
        end
        $display("test random done");
        summarize();
    end
endmodule : mcu_instruction_decode_tb_top
`default_nettype wire
